/* rtl/fp_subtract_defs.vh */
// Constants for the floating-point subtract decode and execute unit.
// Assumes includers are plain Verilog-2005 modules.
`ifndef FP_SUBTRACT_DEFS_VH
`define FP_SUBTRACT_DEFS_VH

// ********************************************************
// Instruction fields
// ********************************************************
`define LINE_F_CODE 4'hF
`define CP_ID_DEFAULT 3'h1
`define W1_LOC_BIT 14
`define OPM_CTRL 7'h28
`define OPM_SINGLE 7'h68
`define OPM_DOUBLE 7'h6C

// ********************************************************
// Source data formats
// ********************************************************
`define FMT_LONG 3'h0
`define FMT_SINGLE 3'h1
`define FMT_EXT 3'h2
`define FMT_PACKED 3'h3
`define FMT_WORD 3'h4
`define FMT_DOUBLE 3'h5
`define FMT_BYTE 3'h6

// ********************************************************
// Addressing modes
// ********************************************************
`define EA_DREG 3'h0
`define EA_AREG 3'h1
`define EA_EXT 3'h7
`define EA_ABS_W 3'h0
`define EA_ABS_L 3'h1
`define EA_PC_DISP 3'h2
`define EA_PC_IDX 3'h3
`define EA_IMM 3'h4

// ********************************************************
// Rounding modes and precisions
// ********************************************************
`define RND_NEAREST 2'h0
`define RND_ZERO 2'h1
`define RND_MINUS 2'h2
`define RND_PLUS 2'h3
`define PREC_EXT 2'h0
`define PREC_SINGLE 2'h1
`define PREC_DOUBLE 2'h2

// ********************************************************
// Extended format constants
// ********************************************************
`define EXP_MAX 15'h7FFF
`define EXP_INT_TOP 15'h401E
`define BIAS_SINGLE_ADJ 15'h3F80
`define BIAS_DOUBLE_ADJ 15'h3C00
`define MANT_INF 64'h8000000000000000
`define MANT_NAN 64'hFFFFFFFFFFFFFFFF
`define MASK_SINGLE 64'hFFFFFF0000000000
`define MASK_DOUBLE 64'hFFFFFFFFFFFFF800
`define RESET_REG 80'h0

`endif

/* rtl/fp_subtract_decode_execute.v */
// Floating-point subtract decode and execute unit with its own register file.
// Assumes the integer core presents a whole two-word instruction together with
// any memory operand already fetched, for one cycle with instr_valid high.
//
// What this block does
// - Destination minus source written back to destination
// - Source converted to extended precision first
// - Select bit picks register or memory source
// - Register mode: specifier names source register
// - Memory mode: specifier decodes data format
// - Packed source raises unimplemented-type exception
// - Opmode selects control, single or double rounding
// - Only data modes; data-direct for short formats
// - Decode indirect modes and mode 111 variants
// - Like-signed infinities give NaN, operand error
// - Exact zero signed by rounding mode
// - Decimal-input inexact flag cleared unless packed
// - Destination field selects minuend and result register
// - Respond only to own coprocessor identifier
`timescale 1ns/100ps
`include "fp_subtract_defs.vh"

module fp_subtract_decode_execute
#(
	parameter [2:0] CP_ID = `CP_ID_DEFAULT,
	parameter NUM_REGS = 8
)
(
	// Clock, reset, enable
	input wire clk,
	input wire sys_rst,
	input wire ce,
	// Instruction from the integer core
	input wire instr_valid,
	input wire [15:0] instr_word0,
	input wire [15:0] instr_word1,
	input wire [79:0] src_operand,
	// Control register settings
	input wire [1:0] round_mode,
	input wire [1:0] ctrl_precision,
	// Register observation port
	input wire [2:0] rd_sel,
	output reg [79:0] rd_data_q,
	// Completion and exceptions
	output reg done_q,
	output reg illegal_ea_q,
	output reg unimpl_type_q,
	output reg [79:0] result_q,
	// Exception byte
	output reg unordered_branch_flag_q,
	output reg operand_error_flag_q,
	output reg divide_by_zero_flag_q,
	output reg inexact_decimal_input_flag_q
);

	// ********************************************************
	// Functions
	// ********************************************************

	// Widen any source format except packed to extended form; packed passes through unchanged
	function [79:0] to_ext;
		input [2:0] fmt;
		input [79:0] d;
		reg [31:0] iv;
		reg [31:0] mag;
		reg [14:0] sh;
		integer i;
		begin
			iv = 32'h0;
			mag = 32'h0;
			sh = 15'h0;
			to_ext = d;
			case (fmt)
				`FMT_LONG, `FMT_WORD, `FMT_BYTE:
				begin
					// Sign-extend, take magnitude, normalise
					if (fmt == `FMT_LONG)
						iv = d[31:0];
					else if (fmt == `FMT_WORD)
						iv = {{16{d[15]}}, d[15:0]};
					else
						iv = {{24{d[7]}}, d[7:0]};
					mag = iv[31] ? (~iv + 32'h1) : iv;
					for (i = 0; i < 31; i = i + 1)
						if (!mag[31] && mag != 32'h0)
						begin
							mag = {mag[30:0], 1'b0};
							sh = sh + 15'h1;
						end
					if (mag == 32'h0)
						to_ext = 80'h0;
					else
						to_ext = {iv[31], `EXP_INT_TOP - sh, mag, 32'h0};
				end
				`FMT_SINGLE:
				begin
					// Denormals are flushed to a signed zero
					if (d[30:23] == 8'h00)
						to_ext = {d[31], 79'h0};
					else if (d[30:23] == 8'hFF)
						to_ext = {d[31], `EXP_MAX, (d[22:0] != 23'h0) ? `MANT_NAN : `MANT_INF};
					else
						to_ext = {d[31], {7'h0, d[30:23]} + `BIAS_SINGLE_ADJ, 1'b1, d[22:0], 40'h0};
				end
				`FMT_DOUBLE:
				begin
					if (d[62:52] == 11'h000)
						to_ext = {d[63], 79'h0};
					else if (d[62:52] == 11'h7FF)
						to_ext = {d[63], `EXP_MAX, (d[51:0] != 52'h0) ? `MANT_NAN : `MANT_INF};
					else
						to_ext = {d[63], {4'h0, d[62:52]} + `BIAS_DOUBLE_ADJ, 1'b1, d[51:0], 11'h0};
				end
				default:
					to_ext = d;
			endcase
		end
	endfunction

	// Finite magnitude subtract a - b, truncating, exact zero signed by mode
	function [79:0] sub_finite;
		input [79:0] a;
		input [79:0] b;
		input [1:0] rmode;
		reg sa;
		reg sb;
		reg [14:0] ea;
		reg [14:0] eb;
		reg [14:0] dexp;
		reg [64:0] ma;
		reg [64:0] mb;
		reg [64:0] sum;
		reg [79:0] t;
		integer i;
		begin
			sa = a[79];
			sb = ~b[79];
			ea = a[78:64];
			eb = b[78:64];
			ma = {1'b0, a[63:0]};
			mb = {1'b0, b[63:0]};
			// Keep the larger magnitude first
			if ({eb, b[63:0]} > {ea, a[63:0]})
			begin
				t = {sa, ea, ma[63:0]};
				sa = sb;
				ea = eb;
				ma = mb;
				sb = t[79];
				eb = t[78:64];
				mb = {1'b0, t[63:0]};
			end
			dexp = ea - eb;
			mb = (dexp > 15'd64) ? 65'h0 : (mb >> dexp);
			if (sa == sb)
			begin
				sum = ma + mb;
				if (sum[64])
				begin
					sum = sum >> 1;
					ea = ea + 15'h1;
				end
			end
			else
			begin
				sum = ma - mb;
				for (i = 0; i < 64; i = i + 1)
					if (!sum[63] && sum != 65'h0)
					begin
						sum = {sum[63:0], 1'b0};
						ea = ea - 15'h1;
					end
			end
			if (sum == 65'h0)
				sub_finite = {(rmode == `RND_MINUS), 79'h0};
			else
				sub_finite = {sa, ea, sum[63:0]};
		end
	endfunction

	// Field class tests on extended values
	function is_inf;
		input [79:0] v;
		begin
			is_inf = (v[78:64] == `EXP_MAX) && (v[62:0] == 63'h0);
		end
	endfunction

	function is_nan;
		input [79:0] v;
		begin
			is_nan = (v[78:64] == `EXP_MAX) && (v[62:0] != 63'h0);
		end
	endfunction

	function is_zero;
		input [79:0] v;
		begin
			is_zero = (v[78:0] == 79'h0);
		end
	endfunction

	// ********************************************************
	// Decode
	// ********************************************************

	reg [79:0] fp_reg [0:NUM_REGS-1]; // Floating-point data registers
	wire [2:0] ea_mode = instr_word0[5:3];
	wire [2:0] ea_reg = instr_word0[2:0];
	wire loc_mem = instr_word1[`W1_LOC_BIT];
	wire [2:0] spec = instr_word1[12:10];
	wire [2:0] dst_sel = instr_word1[9:7];
	wire [6:0] opmode = instr_word1[6:0];
	wire short_fmt = (spec == `FMT_BYTE) || (spec == `FMT_WORD) ||
		(spec == `FMT_LONG) || (spec == `FMT_SINGLE);

	// First word pattern and identifier
	wire is_ours = (instr_word0[15:12] == `LINE_F_CODE) && (instr_word0[11:9] == CP_ID) &&
		(instr_word0[8:6] == 3'h0) && !instr_word1[15] && !instr_word1[13];
	wire op_ok = (opmode == `OPM_CTRL) || (opmode == `OPM_SINGLE) ||
		(opmode == `OPM_DOUBLE);

	// Legal data addressing modes for a memory source
	reg ea_ok;
	always @*
	begin
		ea_ok = 1'b0;
		case (ea_mode)
			`EA_DREG: ea_ok = short_fmt;
			`EA_AREG: ea_ok = 1'b0;
			`EA_EXT: ea_ok = (ea_reg == `EA_ABS_W) || (ea_reg == `EA_ABS_L) ||
				(ea_reg == `EA_IMM) || (ea_reg == `EA_PC_DISP) ||
				(ea_reg == `EA_PC_IDX);
			default: ea_ok = 1'b1;
		endcase
		if (spec == 3'h7)
			ea_ok = 1'b0;
	end

	// Effective address ignored in register mode
	wire bad_ea = loc_mem && !ea_ok;
	wire packed_src = loc_mem && (spec == `FMT_PACKED);
	wire go = instr_valid && is_ours && op_ok;

	// ********************************************************
	// Execute
	// ********************************************************

	wire [79:0] dst_val = fp_reg[dst_sel];
	wire [79:0] src_val = loc_mem ? to_ext(spec, src_operand) : fp_reg[spec];

	// Effective rounding precision
	reg [1:0] prec;
	always @*
	begin
		case (opmode)
			`OPM_SINGLE: prec = `PREC_SINGLE;
			`OPM_DOUBLE: prec = `PREC_DOUBLE;
			default: prec = ctrl_precision;
		endcase
	end

	// Finite subtract, then special-case overrides and precision truncation
	reg [79:0] diff;
	reg op_err;
	always @*
	begin
		op_err = 1'b0;
		diff = sub_finite(dst_val, src_val, round_mode);
		if (is_nan(dst_val) || is_nan(src_val))
			diff = {1'b0, `EXP_MAX, `MANT_NAN};
		else if (is_inf(dst_val) && is_inf(src_val) && (dst_val[79] == src_val[79]))
		begin
			diff = {1'b0, `EXP_MAX, `MANT_NAN};
			op_err = 1'b1;
		end
		else if (is_inf(dst_val))
			diff = dst_val;
		else if (is_inf(src_val))
			diff = {~src_val[79], src_val[78:0]};
		else if (is_zero(src_val) && !is_zero(dst_val))
			diff = dst_val;
		else if (is_zero(dst_val) && !is_zero(src_val))
			diff = {~src_val[79], src_val[78:0]};
		else if (is_zero(dst_val) && is_zero(src_val))
		begin
			if (dst_val[79] != src_val[79])
				diff = {dst_val[79], 79'h0};
			else
				diff = {(round_mode == `RND_MINUS), 79'h0};
		end
		// Forced precision cuts every finite result, zero-operand paths included
		if ((diff[78:64] != `EXP_MAX) && (prec == `PREC_SINGLE))
			diff = {diff[79:64], diff[63:0] & `MASK_SINGLE};
		else if ((diff[78:64] != `EXP_MAX) && (prec == `PREC_DOUBLE))
			diff = {diff[79:64], diff[63:0] & `MASK_DOUBLE};
	end

	// Register file write-back
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g = g + 1)
		begin : regs
			always @(posedge clk)
			begin
				if (sys_rst)
					fp_reg[g] <= `RESET_REG;
				else if (ce && go && !bad_ea && !packed_src && dst_sel == g)
					fp_reg[g] <= diff;
			end
		end
	endgenerate

	// ********************************************************
	// Status and outputs
	// ********************************************************

	// Completion pulses and exception byte updates
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			done_q <= 1'b0;
			illegal_ea_q <= 1'b0;
			unimpl_type_q <= 1'b0;
			result_q <= 80'h0;
			unordered_branch_flag_q <= 1'b0;
			operand_error_flag_q <= 1'b0;
			divide_by_zero_flag_q <= 1'b0;
			inexact_decimal_input_flag_q <= 1'b0;
			rd_data_q <= 80'h0;
		end
		else if (ce)
		begin
			rd_data_q <= fp_reg[rd_sel];
			done_q <= go && !bad_ea && !packed_src;
			illegal_ea_q <= go && bad_ea;
			unimpl_type_q <= go && !bad_ea && packed_src;
			if (go && !bad_ea && !packed_src)
			begin
				// Normal completion
				result_q <= diff;
				unordered_branch_flag_q <= 1'b0;
				divide_by_zero_flag_q <= 1'b0;
				operand_error_flag_q <= op_err;
				inexact_decimal_input_flag_q <= 1'b0;
			end
		end
	end

endmodule

/* sim/fp_subtract_checks_assertions.sv */
// Checker for the subtract unit, watching the top module ports only.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/100ps
module fp_subtract_checks
#(
	parameter [2:0] CP_ID = 3'h1
)
(
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Instruction side
	input wire ce,
	input wire instr_valid,
	input wire [15:0] instr_word0,
	input wire [15:0] instr_word1,
	// Answers and exception byte
	input wire done_q,
	input wire illegal_ea_q,
	input wire unimpl_type_q,
	input wire [79:0] result_q,
	input wire unordered_branch_flag_q,
	input wire divide_by_zero_flag_q,
	input wire inexact_decimal_input_flag_q
);
	// Field views
	wire [6:0] opm = instr_word1[6:0];
	wire [2:0] mode = instr_word0[5:3];
	wire [2:0] spec = instr_word1[12:10];
	wire mem = instr_word1[14];
	// One of the three subtract opmodes
	wire opm_ok = opm == 7'h28 || opm == 7'h68 || opm == 7'h6C;
	// Fixed bits of both words
	wire shape_ok = instr_word0[15:12] == 4'hF && instr_word0[8:6] == 3'h0
		&& !instr_word1[15] && !instr_word1[13];
	// Instruction that the unit must take
	wire take = ce && instr_valid && shape_ok && opm_ok && instr_word0[11:9] == CP_ID;
	wire any_q = done_q || illegal_ea_q || unimpl_type_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_one_answer: assert property ($onehot0({done_q, illegal_ea_q, unimpl_type_q}))
		else $error("more than one answer");
	a_answer_cause: assert property (any_q |-> $past(take))
		else $error("answer without a taken instruction");
	a_foreign_id: assert property (ce && instr_valid && instr_word0[11:9] != CP_ID |=> !any_q)
		else $error("answered a foreign identifier");
	a_reg_done: assert property (take && !mem |=> done_q)
		else $error("register mode not completed");
	a_areg_illegal: assert property (take && mem && mode == 3'h1 |=> illegal_ea_q)
		else $error("address direct accepted");
	a_dreg_format: assert property (take && mem && mode == 3'h0
		&& (spec == 3'h2 || spec == 3'h3 || spec == 3'h5) |=> illegal_ea_q)
		else $error("data direct with long format accepted");
	a_packed_trap: assert property (take && mem && mode >= 3'h2 && mode <= 3'h6
		&& spec == 3'h3 |=> unimpl_type_q)
		else $error("packed source not trapped");
	a_abs_done: assert property (take && mem && mode == 3'h7 && instr_word0[2:0] <= 3'h4
		&& spec == 3'h4 |=> done_q)
		else $error("mode seven form not completed");
	a_flags_clear: assert property (done_q |-> !inexact_decimal_input_flag_q
		&& !divide_by_zero_flag_q && !unordered_branch_flag_q)
		else $error("exception byte not cleared");
	a_result_hold: assert property (!done_q |-> $stable(result_q))
		else $error("result changed without completion");
endmodule

/* sim/int_core_model.sv */
// Integer core model: issues one whole instruction per request.
// Assumes a single clock; drives one step after the rising edge.
`timescale 1ns/100ps
module int_core_model
(
	// Clock
	input wire clk,
	// Instruction to the unit
	output reg instr_valid,
	output reg [15:0] instr_word0,
	output reg [15:0] instr_word1,
	output reg [79:0] src_operand
);
	// Idle until the first request
	initial
	begin
		instr_valid = 1'b0;
		instr_word0 = 16'h0000;
		instr_word1 = 16'h0000;
		src_operand = 80'h0;
	end
	// Hold through the taking edge, then release to inverted values
	task issue(input [15:0] w0, input [15:0] w1, input [79:0] s);
	begin
		@(posedge clk);
		#1;
		instr_valid = 1'b1;
		instr_word0 = w0;
		instr_word1 = w1;
		src_operand = s;
		@(posedge clk);
		#1;
		instr_valid = 1'b0;
		instr_word0 = ~w0;
		instr_word1 = ~w1;
		src_operand = ~s;
	end
	endtask
endmodule

/* sim/fp_subtract_decode_execute_tb_top.sv */
// Self-checking bench for the subtract unit.
// Assumes the core model drives instructions; the bench drives the rest.
`timescale 1ns/100ps
`include "fp_subtract_defs.vh"
module fp_subtract_decode_execute_tb_top;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg ce = 1'b1;
	reg [1:0] round_mode = 2'h0;
	reg [1:0] ctrl_precision = 2'h0;
	reg [2:0] rd_sel = 3'h0;
	wire instr_valid;
	wire [15:0] instr_word0;
	wire [15:0] instr_word1;
	wire [79:0] src_operand;
	wire [79:0] rd_data_q;
	wire [79:0] result_q;
	wire done_q;
	wire illegal_ea_q;
	wire unimpl_type_q;
	wire ub_q;
	wire oe_q;
	wire dz_q;
	wire id_q;
	integer n_mismatch = 0;
	integer n_tests = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] rs = 32'h0000005A;
	reg [79:0] x;
	reg [79:0] r3;
	reg [44:0] t;
	// Extended-format constants worked out here
	wire [79:0] inf = {1'b0, `EXP_MAX, `MANT_INF};
	wire [79:0] m1 = {1'b1, 15'h3FFF, `MANT_INF};
	// Two to the minus forty, and minus one less that value
	wire [79:0] tiny = {1'b0, 15'h3FD7, `MANT_INF};
	wire [79:0] d1 = {1'b1, 15'h3FFF, 64'h8000000000800000};
	// ****
	// Design, core model, clock, timeout
	// ****
	fp_subtract_decode_execute DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.instr_valid(instr_valid), .instr_word0(instr_word0), .instr_word1(instr_word1),
		.src_operand(src_operand), .round_mode(round_mode), .ctrl_precision(ctrl_precision),
		.rd_sel(rd_sel), .rd_data_q(rd_data_q), .done_q(done_q), .illegal_ea_q(illegal_ea_q),
		.unimpl_type_q(unimpl_type_q), .result_q(result_q), .unordered_branch_flag_q(ub_q),
		.operand_error_flag_q(oe_q), .divide_by_zero_flag_q(dz_q),
		.inexact_decimal_input_flag_q(id_q));
	int_core_model cpu (.clk(clk), .instr_valid(instr_valid), .instr_word0(instr_word0),
		.instr_word1(instr_word1), .src_operand(src_operand));
	always #4 clk = ~clk;
	// Cut a hang short
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 1000)
		begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end
	// ****
	// Helpers
	// ****
	function [31:0] xs(input [31:0] v);
		reg [31:0] a;
		begin
			a = v ^ (v << 13);
			a = a ^ (a >> 17);
			xs = a ^ (a << 5);
		end
	endfunction
	function [15:0] f0(input [2:0] m, input [2:0] r);
		f0 = {`LINE_F_CODE, `CP_ID_DEFAULT, 3'h0, m, r};
	endfunction
	function [15:0] f1(input l, input [2:0] s, input [2:0] d, input [6:0] o);
		f1 = {1'b0, l, 1'b0, s, d, o};
	endfunction
	function [79:0] neg(input [79:0] v);
		neg = {~v[79], v[78:0]};
	endfunction
	task chk_w(input [191:0] g, input [191:0] e);
	begin
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	// Issue one instruction, compare {done, illegal, unimplemented}
	task run(input [15:0] a, input [15:0] b, input [79:0] s, input [2:0] k);
	begin
		cpu.issue(a, b, s);
		chk_w({done_q, illegal_ea_q, unimpl_type_q}, k);
	end
	endtask
	task print_verdict;
	begin
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		chk_w({result_q, oe_q}, 81'h0);
		// Random extended loads into zero registers
		for (i = 2; i < 6; i = i + 1)
		begin
			rs = xs(rs);
			x[63:32] = rs | 32'h80000000;
			rs = xs(rs);
			x[31:0] = rs;
			rs = xs(rs);
			x[79:64] = {rs[15], 2'h1, rs[12:0]};
			if (i == 3)
				r3 = neg(x);
			run(f0(i[2:0], 3'h1), f1(1'b1, `FMT_EXT, i[2:0], `OPM_CTRL), x, 3'h4);
			chk_w(result_q, neg(x));
		end
		rd_sel = 3'h3;
		@(posedge clk);
		#1;
		chk_w(rd_data_q, r3);
		run(f0(3'h0, 3'h0), f1(1'b0, 3'h3, 3'h7, `OPM_CTRL), 80'h0, 3'h4);
		chk_w(result_q, neg(r3));
		// Infinities
		run(f0(3'h2, 3'h0), f1(1'b1, `FMT_EXT, 3'h1, `OPM_CTRL), neg(inf), 3'h4);
		chk_w(result_q, inf);
		run(f0(3'h2, 3'h0), f1(1'b1, `FMT_EXT, 3'h1, `OPM_CTRL), inf, 3'h4);
		chk_w({result_q, oe_q}, {1'b0, `EXP_MAX, `MANT_NAN, 1'b1});
		run(f0(3'h2, 3'h0), f1(1'b1, `FMT_EXT, 3'h2, `OPM_CTRL), inf, 3'h4);
		chk_w({result_q, oe_q}, {neg(inf), 1'b0});
		// Zero minus zero in every rounding mode, toward minus last
		for (i = 0; i < 4; i = i + 1)
		begin
			round_mode = i[1:0] ^ {1'b0, i[1]};
			run(f0(3'h0, 3'h0), f1(1'b0, 3'h0, 3'h6, `OPM_CTRL), 80'h0, 3'h4);
			chk_w(result_q, {round_mode == `RND_MINUS, 79'h0});
		end
		// Word integer one converted, then each opmode
		run(f0(`EA_DREG, 3'h0), f1(1'b1, `FMT_WORD, 3'h0, `OPM_CTRL), 80'h1, 3'h4);
		chk_w(result_q, m1);
		// Minus one less a tiny value: single drops the tiny bit, double keeps it
		for (i = 0; i < 3; i = i + 1)
		begin
			ctrl_precision = (i == 1) ? `PREC_EXT : `PREC_SINGLE;
			t[6:0] = (i == 0) ? `OPM_CTRL : (i == 1) ? `OPM_SINGLE : `OPM_DOUBLE;
			run(f0(3'h2, 3'h1), f1(1'b1, `FMT_EXT, 3'h0, t[6:0]), tiny, 3'h4);
			chk_w(result_q, (i == 2) ? d1 : m1);
		end
		ctrl_precision = `PREC_EXT;
		// Legal memory modes, indirect and mode seven forms
		for (i = 0; i < 5; i = i + 1)
		begin
			t[2:0] = (i < 2) ? i[2:0] : (i == 2) ? `EA_IMM : i - 1;
			run(f0(`EA_EXT, t[2:0]), f1(1'b1, `FMT_LONG, 3'h0, `OPM_CTRL), 80'h0, 3'h4);
			run(f0(i[2:0] + 3'h2, 3'h5), f1(1'b1, `FMT_BYTE, 3'h0, `OPM_CTRL), 80'h0, 3'h4);
		end
		// Illegal modes and formats: {mode, reg, spec}
		t = {9'h042, 9'h002, 9'h1E8, 9'h087, 9'h005};
		for (i = 0; i < 5; i = i + 1)
		begin
			run(f0(t[8:6], t[5:3]), f1(1'b1, t[2:0], 3'h0, `OPM_CTRL), 80'h0, 3'h2);
			t = t >> 9;
		end
		run(f0(3'h2, 3'h0), f1(1'b1, `FMT_PACKED, 3'h0, `OPM_CTRL), 80'h0, 3'h1);
		run(f0(3'h2, 3'h0) ^ 16'h0400, f1(1'b1, `FMT_EXT, 3'h0, `OPM_CTRL), inf, 3'h0);
		run(f0(3'h2, 3'h0) | 16'h0040, f1(1'b1, `FMT_EXT, 3'h0, `OPM_CTRL), inf, 3'h0);
		run(f0(3'h2, 3'h0), f1(1'b1, `FMT_EXT, 3'h0, 7'h29), inf, 3'h0);
		// Clock enable low: a self-subtract of register zero must not land
		ce = 1'b0;
		run(f0(3'h0, 3'h0), f1(1'b0, 3'h0, 3'h0, `OPM_CTRL), 80'h0, 3'h0);
		ce = 1'b1;
		rd_sel = 3'h0;
		@(posedge clk);
		#1;
		chk_w({rd_data_q, result_q, id_q, ub_q, dz_q}, {d1, d1, 3'h0});
		print_verdict;
	end
endmodule
bind fp_subtract_decode_execute fp_subtract_checks #(.CP_ID(CP_ID)) u_chk (.clk(clk),
	.sys_rst(sys_rst), .ce(ce), .instr_valid(instr_valid), .instr_word0(instr_word0),
	.instr_word1(instr_word1), .done_q(done_q), .illegal_ea_q(illegal_ea_q),
	.unimpl_type_q(unimpl_type_q), .result_q(result_q),
	.unordered_branch_flag_q(unordered_branch_flag_q),
	.divide_by_zero_flag_q(divide_by_zero_flag_q),
	.inexact_decimal_input_flag_q(inexact_decimal_input_flag_q));
